/* File: design/fns_regs.svh */
`ifndef FNS_REGS_SVH
`define FNS_REGS_SVH

`define FNS_AW 5
`define FNS_DW 8

`define FNS_ADDR_FRAC0 5'h00
`define FNS_ADDR_FRAC1 5'h01
`define FNS_ADDR_FRAC2 5'h02
`define FNS_ADDR_FRAC3 5'h03
`define FNS_ADDR_REFEN 5'h05
`define FNS_ADDR_INTLO 5'h06
`define FNS_ADDR_INTHI 5'h07
`define FNS_ADDR_HALVE 5'h0A
`define FNS_ADDR_CALCTL 5'h18
`define FNS_ADDR_CALTIME 5'h19
`define FNS_ADDR_BAND 5'h1B
`define FNS_ADDR_OUTDIV 5'h1C
`define FNS_ADDR_REFCFG 5'h1D
`define FNS_ADDR_POWER 5'h1E
`define FNS_ADDR_STATUS 5'h1F

`define FNS_BIT_REFEN 4
`define FNS_BIT_HALVE 6
`define FNS_BIT_CALBYP 0
`define FNS_BIT_BAND 4
`define FNS_BIT_DOUBLER 5
`define FNS_BIT_PDOWN 0

`define FNS_RST_CALTIME 8'h64
`define FNS_RST_REFRATIO 5'h01
`define FNS_RST_OUTDIV 3'h0

`define FNS_FRACTIONAL_DIVIDE_WORD_BITS 25
`define FNS_INT_MIN 12'h017
`define FNS_INT_MAX 12'hFFF
`define FNS_CAL_MULT 16'h001C
`define FNS_OUTDIV_MAX 3'h4
`define FNS_QUAD_BASE 6'h02
`define FNS_REF_FULL 8'h20
`define FNS_BAND_COUNT 18'h00030
`define FNS_BAND_SHIFT 12

`define FNS_SETTLE_US 170
`define FNS_NS_PER_US 1000
`define FNS_CLK_PERIOD_NS 25

`endif

/* File: design/fns_pkg.sv */
package fns_pkg;
    typedef enum logic [1:0] {
        FNS_IDLE,
        FNS_CAL,
        FNS_ACQ,
        FNS_LOCK
    } fns_state_e;
endpackage

/* File: design/fns_ref_div.sv */
`timescale 1ns/10ps
`include "fns_regs.svh"

module fns_ref_div (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic doubler,
    input wire logic halve,
    input wire logic [4:0] ratio,
    output logic pfd_tick
);
    logic [7:0] acc_q;
    logic [7:0] acc_d;
    logic tick_d;
    logic [7:0] r_eff;
    logic [7:0] term;
    logic [7:0] sum;
    logic [7:0] rem;

    always_comb begin
        r_eff = (ratio == 5'h00) ? `FNS_REF_FULL : {3'h0, ratio};
        // Bypass drops both the 5-bit divider and the halving stage.
        term = enable ? (halve ? (r_eff << 1) : r_eff) : 8'h01;
        sum = acc_q + (doubler ? 8'h02 : 8'h01);
        rem = sum - term;
        tick_d = 1'b0;
        acc_d = sum;
        if (sum >= term) begin
            tick_d = 1'b1;
            acc_d = (rem >= term) ? 8'h00 : rem;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_q <= 8'h00;
            pfd_tick <= 1'b0;
        end else begin
            acc_q <= acc_d;
            pfd_tick <= tick_d;
        end
    end

    chk_ref_bypass: assert property (@(posedge clk) disable iff (!rst_n)
        (!enable && !doubler) [*2] |-> pfd_tick)
        else $error("bypassed reference path did not tick every cycle");
endmodule

/* File: design/fns_ctrl.sv */
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps
`include "fns_regs.svh"

module fns_ctrl #(
    parameter int unsigned SETTLE_CYCLES =
        `FNS_SETTLE_US * `FNS_NS_PER_US / `FNS_CLK_PERIOD_NS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [`FNS_AW-1:0] addr,
    input wire logic [`FNS_DW-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [`FNS_DW-1:0] rdata_q,
    input wire logic freq_locked,
    output logic pfd_tick,
    output logic [12:0] fb_ratio_q,
    output logic ratio_valid_q,
    output logic [2:0] output_divider_select_q,
    output logic [5:0] lo_div_ratio_q,
    output logic out_div_valid_q,
    output logic band_flag_q,
    output logic lock_indicator_q,
    output logic tuning_to_ref_q,
    output logic [1:0] osc_sel_q,
    output logic [3:0] band_sel_q,
    output logic ref_series_closed_q,
    output logic reference_shunt_switch_q
);
    function automatic logic int_in_range(input logic [11:0] v);
        return (v >= `FNS_INT_MIN) && (v <= `FNS_INT_MAX);
    endfunction
    function automatic logic div_code_ok(input logic [2:0] c);
        return c <= `FNS_OUTDIV_MAX;
    endfunction

    logic [`FNS_FRACTIONAL_DIVIDE_WORD_BITS-1:0] fractional_divide_word_q, fractional_divide_word_d;
    logic [11:0] int_q, int_d;
    logic refen_q, refen_d, halve_q, halve_d, doubler_q, doubler_d;
    logic [4:0] ref_ratio_q, ref_ratio_d;
    logic cal_bypass_q, cal_bypass_d, band_flag_d, pdown_q, pdown_d, start;
    logic [7:0] calibration_time_divider_q, caltime_d;
    logic [2:0] outdiv_d;
    assign start = wr_en && (addr == `FNS_ADDR_FRAC0);

    always_comb begin
        fractional_divide_word_d = fractional_divide_word_q;
        int_d = int_q;
        refen_d = refen_q;
        halve_d = halve_q;
        doubler_d = doubler_q;
        ref_ratio_d = ref_ratio_q;
        cal_bypass_d = cal_bypass_q;
        caltime_d = calibration_time_divider_q;
        band_flag_d = band_flag_q;
        outdiv_d = output_divider_select_q;
        pdown_d = pdown_q;
        if (wr_en) begin
            case (addr)
                `FNS_ADDR_FRAC0: fractional_divide_word_d[7:0] = wdata;
                `FNS_ADDR_FRAC1: fractional_divide_word_d[15:8] = wdata;
                `FNS_ADDR_FRAC2: fractional_divide_word_d[23:16] = wdata;
                `FNS_ADDR_FRAC3: fractional_divide_word_d[24] = wdata[0];
                `FNS_ADDR_INTLO: int_d[7:0] = wdata;
                `FNS_ADDR_INTHI: int_d[11:8] = wdata[3:0];
                `FNS_ADDR_REFEN: refen_d = wdata[`FNS_BIT_REFEN];
                `FNS_ADDR_HALVE: halve_d = wdata[`FNS_BIT_HALVE];
                `FNS_ADDR_REFCFG: begin
                    ref_ratio_d = wdata[4:0];
                    doubler_d = wdata[`FNS_BIT_DOUBLER];
                end
                `FNS_ADDR_CALCTL: cal_bypass_d = wdata[`FNS_BIT_CALBYP];
                `FNS_ADDR_CALTIME: caltime_d = wdata;
                `FNS_ADDR_BAND: band_flag_d = wdata[`FNS_BIT_BAND];
                `FNS_ADDR_OUTDIV: outdiv_d = wdata[2:0];
                `FNS_ADDR_POWER: pdown_d = wdata[`FNS_BIT_PDOWN];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fractional_divide_word_q <= '0;
            int_q <= 12'h000;
            refen_q <= 1'b0;
            halve_q <= 1'b0;
            doubler_q <= 1'b0;
            ref_ratio_q <= `FNS_RST_REFRATIO;
            cal_bypass_q <= 1'b0;
            calibration_time_divider_q <= `FNS_RST_CALTIME;
            band_flag_q <= 1'b0;
            output_divider_select_q <= `FNS_RST_OUTDIV;
            pdown_q <= 1'b0;
        end else begin
            fractional_divide_word_q <= fractional_divide_word_d;
            int_q <= int_d;
            refen_q <= refen_d;
            halve_q <= halve_d;
            doubler_q <= doubler_d;
            ref_ratio_q <= ref_ratio_d;
            cal_bypass_q <= cal_bypass_d;
            calibration_time_divider_q <= caltime_d;
            band_flag_q <= band_flag_d;
            output_divider_select_q <= outdiv_d;
            pdown_q <= pdown_d;
        end
    end

    fns_ref_div u_ref_div (
        .clk(clk),
        .rst_n(rst_n),
        .enable(refen_q),
        .doubler(doubler_q),
        .halve(halve_q),
        .ratio(ref_ratio_q),
        .pfd_tick(pfd_tick)
    );

    fns_pkg::fns_state_e state_q, state_d;
    logic [15:0] cal_cnt_q, cal_cnt_d, cal_load;
    logic [31:0] settle_q, settle_d;
    logic overtime_q, overtime_d;
    logic [1:0] osc_d;
    logic [3:0] band_d;
    logic [17:0] band_idx;
    logic [`FNS_FRACTIONAL_DIVIDE_WORD_BITS-1:0] fractional_divide_word_acc_q, fractional_divide_word_acc_d;
    logic [`FNS_FRACTIONAL_DIVIDE_WORD_BITS:0] fractional_divide_word_sum;
    logic [12:0] fb_ratio_d;
    logic [5:0] lo_ratio_d;
    logic [`FNS_DW-1:0] rdata_d;

    always_comb begin
        cal_load = {8'h00, calibration_time_divider_q} * `FNS_CAL_MULT;
        band_idx = ({6'h00, int_q} * `FNS_BAND_COUNT) >> `FNS_BAND_SHIFT;
        state_d = state_q;
        cal_cnt_d = cal_cnt_q;
        settle_d = settle_q;
        overtime_d = overtime_q;
        osc_d = osc_sel_q;
        band_d = band_sel_q;
        if (start) begin
            // A restart from any state drops lock and recalibrates, or goes straight to FNS_ACQ when cal_bypass_q is set.
            settle_d = '0;
            overtime_d = 1'b0;
            if (cal_bypass_q) begin
                state_d = fns_pkg::FNS_ACQ;
            end else begin
                state_d = fns_pkg::FNS_CAL;
                cal_cnt_d = cal_load;
                osc_d = band_idx[5:4];
                band_d = band_idx[3:0];
            end
        end else begin
            unique case (state_q)
                fns_pkg::FNS_IDLE: ;
                fns_pkg::FNS_CAL: begin
                    if (pfd_tick) begin
                        if (cal_cnt_q <= 16'h0001) begin
                            state_d = fns_pkg::FNS_ACQ;
                        end else begin
                            cal_cnt_d = cal_cnt_q - 16'h0001;
                        end
                    end
                end
                fns_pkg::FNS_ACQ: begin
                    if (freq_locked) begin
                        state_d = fns_pkg::FNS_LOCK;
                    end else if (settle_q < SETTLE_CYCLES) begin
                        settle_d = settle_q + 32'h1;
                    end else begin
                        overtime_d = 1'b1;
                    end
                end
                fns_pkg::FNS_LOCK: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= fns_pkg::FNS_IDLE;
            cal_cnt_q <= 16'h0000;
            settle_q <= '0;
            overtime_q <= 1'b0;
            osc_sel_q <= 2'h0;
            band_sel_q <= 4'h0;
            lock_indicator_q <= 1'b0;
            tuning_to_ref_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cal_cnt_q <= cal_cnt_d;
            settle_q <= settle_d;
            overtime_q <= overtime_d;
            osc_sel_q <= osc_d;
            band_sel_q <= band_d;
            lock_indicator_q <= (state_d == fns_pkg::FNS_LOCK);
            tuning_to_ref_q <= (state_d == fns_pkg::FNS_CAL);
        end
    end

    always_comb begin
        fractional_divide_word_sum = {1'b0, fractional_divide_word_acc_q} + {1'b0, fractional_divide_word_q};
        fractional_divide_word_acc_d = fractional_divide_word_acc_q;
        fb_ratio_d = fb_ratio_q;
        if (start) begin
            fractional_divide_word_acc_d = '0;
        end else if (pfd_tick) begin
            // Modulus overflow adds one to the next feedback count.
            fractional_divide_word_acc_d = fractional_divide_word_sum[`FNS_FRACTIONAL_DIVIDE_WORD_BITS-1:0];
            fb_ratio_d = {1'b0, int_q} + {12'h000, fractional_divide_word_sum[`FNS_FRACTIONAL_DIVIDE_WORD_BITS]};
        end
        lo_ratio_d = div_code_ok(output_divider_select_q) ?
            (`FNS_QUAD_BASE << output_divider_select_q) : 6'h00;
        rdata_d = '0;
        if (rd_en) begin
            case (addr)
                `FNS_ADDR_FRAC0: rdata_d = fractional_divide_word_q[7:0];
                `FNS_ADDR_FRAC1: rdata_d = fractional_divide_word_q[15:8];
                `FNS_ADDR_FRAC2: rdata_d = fractional_divide_word_q[23:16];
                `FNS_ADDR_FRAC3: rdata_d = {7'h00, fractional_divide_word_q[24]};
                `FNS_ADDR_INTLO: rdata_d = int_q[7:0];
                `FNS_ADDR_INTHI: rdata_d = {4'h0, int_q[11:8]};
                `FNS_ADDR_REFEN: rdata_d[`FNS_BIT_REFEN] = refen_q;
                `FNS_ADDR_HALVE: rdata_d[`FNS_BIT_HALVE] = halve_q;
                `FNS_ADDR_REFCFG: begin
                    rdata_d[4:0] = ref_ratio_q;
                    rdata_d[`FNS_BIT_DOUBLER] = doubler_q;
                end
                `FNS_ADDR_CALCTL: rdata_d[`FNS_BIT_CALBYP] = cal_bypass_q;
                `FNS_ADDR_CALTIME: rdata_d = calibration_time_divider_q;
                `FNS_ADDR_BAND: rdata_d[`FNS_BIT_BAND] = band_flag_q;
                `FNS_ADDR_OUTDIV: rdata_d = {5'h00, output_divider_select_q};
                `FNS_ADDR_POWER: rdata_d[`FNS_BIT_PDOWN] = pdown_q;
                `FNS_ADDR_STATUS: rdata_d = {2'h0, osc_sel_q, ratio_valid_q,
                    overtime_q, tuning_to_ref_q, lock_indicator_q};
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fractional_divide_word_acc_q <= '0;
            fb_ratio_q <= 13'h0000;
            ratio_valid_q <= 1'b0;
            lo_div_ratio_q <= 6'h00;
            out_div_valid_q <= 1'b0;
            rdata_q <= '0;
            ref_series_closed_q <= 1'b1;
            reference_shunt_switch_q <= 1'b0;
        end else begin
            fractional_divide_word_acc_q <= fractional_divide_word_acc_d;
            fb_ratio_q <= fb_ratio_d;
            ratio_valid_q <= int_in_range(int_q);
            lo_div_ratio_q <= lo_ratio_d;
            out_div_valid_q <= div_code_ok(output_divider_select_q);
            rdata_q <= rdata_d;
            ref_series_closed_q <= !pdown_q;
            reference_shunt_switch_q <= pdown_q;
        end
    end

    logic [15:0] chk_ticks_q, chk_expect_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chk_ticks_q <= 16'h0000;
            chk_expect_q <= 16'h0001;
        end else if (start) begin
            chk_ticks_q <= 16'h0000;
            chk_expect_q <= (cal_load == 16'h0000) ? 16'h0001 : cal_load;
        end else if (state_q == fns_pkg::FNS_CAL && pfd_tick) begin
            chk_ticks_q <= chk_ticks_q + 16'h0001;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence seq_cal_start;
        start && !cal_bypass_q;
    endsequence
    sequence seq_cal_window;
        tuning_to_ref_q && !lock_indicator_q;
    endsequence

    chk_start_drops_lock: assert property (start |=> !lock_indicator_q)
        else $error("lock indicator stayed high after acquisition start");
    chk_cal_entry: assert property (seq_cal_start |=> seq_cal_window)
        else $error("calibration did not hold tuning after start");
    chk_cal_skip: assert property (start && cal_bypass_q ##1 !start
        |-> !tuning_to_ref_q && state_q == fns_pkg::FNS_ACQ)
        else $error("bypassed calibration still held tuning");
    chk_cal_length: assert property ($fell(tuning_to_ref_q) && !$past(start)
        |-> chk_ticks_q == chk_expect_q)
        else $error("calibration interval length wrong");
    chk_abort_restart: assert property (
        state_q == fns_pkg::FNS_ACQ ##0 seq_cal_start
        |=> state_q == fns_pkg::FNS_CAL ##0 !lock_indicator_q)
        else $error("write during acquisition did not restart calibration");
    chk_lock_cause: assert property ($rose(lock_indicator_q)
        |-> $past(freq_locked) && $past(state_q) == fns_pkg::FNS_ACQ)
        else $error("lock indicator rose without lock in acquisition");
    chk_pd_switches: assert property (pdown_q [*2]
        |-> !ref_series_closed_q && reference_shunt_switch_q)
        else $error("reference switches wrong in power-down");
    chk_ratio_range: assert property (##1 ratio_valid_q
        == int_in_range($past(int_q)))
        else $error("feedback ratio range flag wrong");
    chk_fractional_divide_word_carry: assert property (pfd_tick && !start |=> fb_ratio_q
        == {1'b0, $past(int_q)}
        + {12'h000, $past(fractional_divide_word_sum[`FNS_FRACTIONAL_DIVIDE_WORD_BITS])})
        else $error("feedback ratio does not follow modulus carry");
    chk_out_ratio: assert property (div_code_ok(output_divider_select_q)
        ##1 $stable(output_divider_select_q) |-> lo_div_ratio_q
        == (`FNS_QUAD_BASE << output_divider_select_q))
        else $error("output divider ratio wrong");
endmodule

/* File: bench/fns_loop_model.sv */
`timescale 1ns/10ps

module fns_loop_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic acq_start,
    input wire logic tuning_to_ref_q,
    input wire logic [7:0] settle,
    output logic freq_locked
);
    logic [7:0] cnt_q;

    // The loop settles only while tuning is back on the filter.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 8'h00;
        end else if (acq_start || tuning_to_ref_q) begin
            cnt_q <= 8'h00;
        end else if (cnt_q != settle) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    // Error falls below the lock threshold a set time later.
    assign freq_locked = rst_n && !acq_start && !tuning_to_ref_q &&
        (cnt_q == settle);
endmodule

/* File: bench/fns_ctrl_test.sv */
`timescale 1ns/10ps

module fns_ctrl_test;
    logic clk;
    logic rst_n;
    logic [4:0] addr;
    logic [7:0] wdata;
    logic wr_en;
    logic rd_en;
    logic acq_start;
    logic [7:0] settle;
    logic [7:0] rdata_q;
    logic freq_locked;
    logic pfd_tick;
    logic [12:0] fb_q;
    logic rvld_q;
    logic [2:0] osel_q;
    logic [5:0] lo_q;
    logic ovld_q;
    logic band_q;
    logic lock_q;
    logic tune_q;
    logic [1:0] osc_q;
    logic [3:0] bsel_q;
    logic ser_q;
    logic shunt_q;
    logic [31:0] seed;
    logic [31:0] t;
    logic [11:0] int_v;
    logic [11:0] v;
    logic [7:0] d;
    logic [7:0] pc [6] = '{8'h45, 8'h85, 8'hC5, 8'hE3, 8'hC0, 8'hA7};
    logic [4:0] ra [13] = '{5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h07,
        5'h0A, 5'h18, 5'h19, 5'h1B, 5'h1C, 5'h1D, 5'h1E};
    logic [7:0] rm [13] = '{8'hFF, 8'hFF, 8'h01, 8'h10, 8'hFF, 8'h0F,
        8'h40, 8'h01, 8'hFF, 8'h10, 8'h07, 8'h3F, 8'h01};
    int i;
    int j;
    int nt;
    int c;
    int bad;
    int n_fail;
    int n_tests;

    fns_ctrl #(.SETTLE_CYCLES(20)) u_dut (
        .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata_q(rdata_q),
        .freq_locked(freq_locked), .pfd_tick(pfd_tick),
        .fb_ratio_q(fb_q), .ratio_valid_q(rvld_q),
        .output_divider_select_q(osel_q), .lo_div_ratio_q(lo_q),
        .out_div_valid_q(ovld_q), .band_flag_q(band_q),
        .lock_indicator_q(lock_q), .tuning_to_ref_q(tune_q),
        .osc_sel_q(osc_q), .band_sel_q(bsel_q),
        .ref_series_closed_q(ser_q), .reference_shunt_switch_q(shunt_q)
    );

    fns_loop_model u_loop (
        .clk(clk), .rst_n(rst_n), .acq_start(acq_start),
        .tuning_to_ref_q(tune_q), .settle(settle),
        .freq_locked(freq_locked)
    );

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic int pfd_exp(input logic [7:0] p);
        int r;
        r = (p[4:0] == 5'h00) ? 32 : int'(p[4:0]);
        if (!p[7]) begin
            r = 1;
        end
        return 480 * (1 + int'(p[5])) / (r * (1 + int'(p[6] & p[7])));
    endfunction

    task automatic test_done();
        if (n_fail == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string s, input logic [15:0] x,
                       input logic [15:0] y);
        n_tests++;
        if (y !== x) begin
            n_fail++;
            $display("BAD %s exp %h got %h", s, x, y);
        end
    endtask

    task automatic ok(input string s, input logic b);
        n_tests++;
        if (b !== 1'b1) begin
            n_fail++;
            $display("BAD %s exp 1 got %b", s, b);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] x);
        addr <= a;
        wdata <= x;
        wr_en <= 1'b1;
        rd_en <= 1'b0;
        acq_start <= (a == 5'h00);
        @(posedge clk);
    endtask

    task automatic rd(input logic [4:0] a, output logic [7:0] x);
        addr <= a;
        wr_en <= 1'b0;
        rd_en <= 1'b1;
        acq_start <= 1'b0;
        @(posedge clk);
        #1;
        x = rdata_q;
    endtask

    task automatic step(input int n);
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        acq_start <= 1'b0;
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic rdc(input logic [4:0] a, input logic [7:0] x);
        logic [7:0] y;
        rd(a, y);
        chk("rd", 16'(x), 16'(y));
    endtask

    task automatic set_int(input logic [11:0] x);
        wr(5'h06, x[7:0]);
        wr(5'h07, {4'h0, x[11:8]});
        int_v = x;
    endtask

    task automatic acq(input int n, input logic byp);
        int k;
        int m;
        logic fl;
        logic [5:0] x;
        logic [17:0] e;
        logic [7:0] y;
        e = ({6'h00, int_v} * 18'h00030) >> 12;
        x = byp ? {osc_q, bsel_q} : e[5:0];
        t = rnd();
        wr(5'h00, t[7:0]);
        step(0);
        chk("sel", 16'(x), 16'({osc_q, bsel_q}));
        ok("start", !lock_q && tune_q === !byp);
        m = 0;
        fl = 1'b0;
        for (k = 0; k < 2000 && lock_q !== 1'b1; k++) begin
            m = m + int'(tune_q && pfd_tick);
            fl = freq_locked;
            @(posedge clk);
            #1;
        end
        ok("ncal", m <= n + 1 && m + 1 >= n);
        ok("lock", lock_q && fl);
        step(6);
        rd(5'h1F, y);
        chk("stat", 16'({2'h0, x[5:4], int_v >= 12'h017, 3'h1}),
            16'(y));
    endtask

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        test_done();
    end

    initial begin
        rst_n = 1'b0;
        addr = 5'h00;
        wdata = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        acq_start = 1'b0;
        settle = 8'h04;
        seed = 32'h0000D80E;
        int_v = 12'h000;
        n_fail = 0;
        n_tests = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        step(1);
        ok("rst", ser_q && !shunt_q && !lock_q && !tune_q);
        for (i = 0; i < 32; i++) begin
            rdc(5'(i), i == 25 ? 8'h64 : (i == 29 ? 8'h01 : 8'h00));
        end
        for (j = 0; j < 3; j++) begin
            for (i = 0; i < 13; i++) begin
                t = rnd();
                wr(ra[i], t[7:0]);
                rdc(ra[i], t[7:0] & rm[i]);
            end
        end
        wr(5'h04, 8'hFF);
        rdc(5'h04, 8'h00);
        wr(5'h1E, 8'h01);
        step(2);
        ok("pdn", !ser_q && shunt_q);
        wr(5'h1E, 8'h00);
        step(2);
        ok("pup", ser_q && !shunt_q);
        for (i = 0; i < 6; i++) begin
            wr(5'h05, {3'h0, pc[i][7], 4'h0});
            wr(5'h0A, {1'b0, pc[i][6], 6'h00});
            wr(5'h1D, {2'h0, pc[i][5:0]});
            step(8);
            nt = 0;
            repeat (480) begin
                nt = nt + int'(pfd_tick);
                @(posedge clk);
                #1;
            end
            c = pfd_exp(pc[i]);
            ok("pfd", nt <= c + 1 && nt + 1 >= c);
        end
        for (i = 0; i < 8; i++) begin
            wr(5'h1C, {5'h00, 3'(i)});
            wr(5'h1B, {3'h0, i == 0, 4'h0});
            step(2);
            chk("odiv", 16'(i), 16'(osel_q));
            chk("lo", i < 5 ? 16'(2 << i) : 16'h0000, 16'(lo_q));
            ok("ovld", ovld_q === (i < 5));
            ok("band", band_q === (i == 0));
        end
        for (i = 0; i < 4; i++) begin
            t = rnd();
            v = (i == 0) ? 12'h016 : (i == 1) ? 12'h017 : (i == 2) ?
                12'hFFF : 12'h017 + 12'(t % 32'h00000FE9);
            set_int(v);
            step(2);
            ok("rvld", rvld_q === (v >= 12'h017));
        end
        wr(5'h05, 8'h00);
        wr(5'h1D, 8'h01);
        wr(5'h18, 8'h01);
        for (i = 1; i < 4; i++) begin
            wr(5'h03, {7'h00, i[1]});
            wr(5'h02, {i[0], 7'h00});
            wr(5'h01, 8'h00);
            wr(5'h00, 8'h00);
            step(4);
            nt = 0;
            c = 0;
            bad = 0;
            repeat (64) begin
                if (pfd_tick) begin
                    nt++;
                    c = c + int'(fb_q == {1'b0, int_v} + 13'h0001);
                    bad = bad + int'(fb_q != {1'b0, int_v} &&
                        fb_q != {1'b0, int_v} + 13'h0001);
                end
                @(posedge clk);
                #1;
            end
            ok("fbr", bad == 0 && nt > 60);
            ok("fractional_divide_word", 4 * c <= i * nt + 4 && i * nt <= 4 * c + 4);
        end
        wr(5'h18, 8'h00);
        wr(5'h19, 8'h02);
        acq(56, 1'b0);
        wr(5'h18, 8'h01);
        wr(5'h00, 8'h5A);
        wr(5'h18, 8'h00);
        wr(5'h00, 8'hA5);
        step(10);
        ok("abrt", !lock_q && tune_q);
        acq(56, 1'b0);
        set_int(12'hFFF);
        wr(5'h0A, 8'h00);
        wr(5'h05, 8'h10);
        wr(5'h1D, 8'h03);
        wr(5'h19, 8'h01);
        acq(28, 1'b0);
        wr(5'h18, 8'h01);
        acq(0, 1'b1);
        step(1);
        test_done();
    end
endmodule
